// >>> vectored_interrupt_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_tb_top;
    logic                ref_clk_i = 1'b0;
    logic                rst_n_i = 1'b0;
    logic [14:0]         ev = 15'h0000, en = 15'h0000, clr = 15'h0000, flags;
    vic_pkg::vic_instr_t ins = 3'h0;
    vic_pkg::vic_vec_t   vec;
    logic                gie, ack, rfetch;
    logic                ce = 1'b1;
    logic [3:0]          lat = 4'h0;
    logic [11:0]         got;
    int                  n_mismatch = 0, num_checks = 0;
    vic_top u_vic_top (.ref_clk_i, .rst_n_i, .clk_en_i(ce), .src_event_i(ev),
        .src_enable_i(en), .flag_clear_i(clr), .instr_i(ins), .vec_ack_i(ack), .vec_o(vec),
        .flags_o(flags), .gie_o(gie), .reset_fetch_o(rfetch));
    vic_fetch_model u_vic_fetch_model (.clk_i(ref_clk_i), .vec_i(vec), .lat_i(lat),
        .ack_o(ack), .got_o(got));
    // Core clock, 25 ns
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [15:0] a, input logic [15:0] e);
        num_checks++;
        if (a !== e)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic step(input logic [14:0] e, input logic [14:0] c, input logic [2:0] i);
        @(negedge ref_clk_i);
        ev = e;
        clr = c;
        ins = i;
        @(negedge ref_clk_i);
        {ev, clr, ins} = 33'h0;
    endtask
    task automatic wait_ack(input logic [11:0] e);
        int n;
        n = 0;
        while (ack !== 1'b1 && n < 40)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 40)
        begin
            n_mismatch++;
            tally_and_finish();
        end
        check({4'h0, got}, {4'h0, e});
        // Let the acknowledge edge update global enable and the vector
        @(negedge ref_clk_i);
    endtask
    task automatic t_vectors();
        for (int k = 0; k < 15; k++)
        begin
            lat = k[3:0];
            en = 15'h0001 << k;
            step(15'h0000, 15'h0000, 3'h4);
            step(en, 15'h0000, 3'h0);
            wait_ack(vic_pkg::VEC_TABLE[k]);
            en = 15'h0000;
            check({gie, flags}, {1'b0, 15'h0001 << k});
            step(15'h0000, 15'h0001 << k, 3'h1);
            check({gie, flags}, 16'h8000);
        end
        $display("t_vectors done");
    endtask
    task automatic t_order();
        lat = 4'h0;
        en = 15'h0208;
        step(15'h0000, 15'h0000, 3'h2);
        step(15'h4208, 15'h0000, 3'h0);
        repeat (3) @(negedge ref_clk_i);
        check({vec.valid, flags}, 16'h4208);
        step(15'h0000, 15'h0000, 3'h4);
        wait_ack(vic_pkg::VEC_TABLE[3]);
        step(15'h0000, 15'h0008, 3'h1);
        wait_ack(vic_pkg::VEC_TABLE[9]);
        $display("t_order done");
    endtask
    // Clock enable low freezes flags against new events
    task automatic t_freeze();
        ce = 1'b0;
        step(15'h0002, 15'h0000, 3'h0);
        check({1'b0, flags}, 16'h4200);
        ce = 1'b1;
        $display("t_freeze done");
    endtask
    // Reset, reset vector, then the scenarios
    initial
    begin
        repeat (8) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        check({15'h0000, rfetch}, 16'h0001);
        wait_ack(12'h000);
        check({gie, flags}, 16'h0000);
        check({15'h0000, rfetch}, 16'h0000);
        $display("t_reset done");
        t_vectors();
        t_order();
        t_freeze();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> vic_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_fetch_model (
    input  wire logic              clk_i,
    input  wire vic_pkg::vic_vec_t vec_i,
    input  wire logic [3:0]        lat_i,
    output logic                   ack_o,
    output logic [11:0]            got_o
);
    logic [3:0] cnt_reg;
    // Takes a vector after lat_i waiting cycles and fetches from it
    always_ff @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        cnt_reg <= 4'h0;
        if (vec_i.valid && !ack_o && cnt_reg == lat_i)
        begin
            ack_o <= 1'b1;
            got_o <= vec_i.addr;
        end
        else if (vec_i.valid && !ack_o) cnt_reg <= cnt_reg + 4'h1;
    end
endmodule
`default_nettype wire

// >>> vic_pkg.sv
//==============================================================================
// Overview of operation
// [RL1] Fifteen sources, each own flag and vector
// [RL2] Reset fetches vector 0000, top priority
// [RL3] Watchdog enable gates flag, vector 0003
// [RL4] Pin0 needs global and own enable, 0006
// [RL5] Main timer overflow vectors to 0009
// [RL6] Pin1 vectors to 000F, priority 4
// [RL7] Time base vectors to 0012, priority 5
// [RL8] Serial transmit empty vectors to 0015
// [RL9] Serial receive full vectors to 0018
// [RL10] Serial receive error vectors to 001B
// [RL11] Timer three vectors to 0021
// [RL12] Sync serial port vectors to 0024
// [RL13] Timer four vectors to 0027
// [RL14] Pin3 vectors to 002A, priority 12
// [RL15] Converter done vectors to 0030
// [RL16] Timer two vectors to 0033
// [RL17] Pin5 vectors to 0036, lowest
// [RL18] Three status, two masks, instruction global enable
// [RL19] Enabled interrupt redirects next fetch to vector
// [RL20] Software clears flag before leaving service
// [RL21] Flags set regardless of mask or global
// [RL22] Return instruction re-enables global interrupts
// [RL23] Smallest priority number wins when several pend
//==============================================================================
package vic_pkg;

    // Source count and vector width
    localparam int NUM_SRC = 15;
    localparam int VEC_W   = 12;

    // Reset values
    localparam logic [14:0] FLAG_RST   = 15'h0000;
    localparam logic [14:0] ENABLE_RST = 15'h0000;
    localparam logic        GIE_RST    = 1'b0;

    // Reset vector
    localparam logic [VEC_W-1:0] RESET_VECTOR = 12'h000;

    // Vector table, index = priority minus one
    localparam logic [VEC_W-1:0] VEC_TABLE [NUM_SRC] = '{
        12'h003, 12'h006, 12'h009, 12'h00f, 12'h012,
        12'h015, 12'h018, 12'h01b, 12'h021, 12'h024,
        12'h027, 12'h02a, 12'h030, 12'h033, 12'h036
    };

    // Source index positions
    localparam int SRC_WATCHDOG = 0;

    // Instruction event bundle from the core
    typedef struct packed {
        logic enable_instr;   // global_irq_enable_instr
        logic disable_instr;  // global_irq_disable_instr
        logic return_instr;   // return_from_irq_instr
    } vic_instr_t;

    // Vector request to instruction fetch
    typedef struct packed {
        logic             valid;
        logic [VEC_W-1:0] addr;
        logic [3:0]       prio;
    } vic_vec_t;

endpackage

// >>> vic_top.sv
`timescale 1ns/1ps
`default_nettype none

module vic_top #(
    parameter int NUM_SRC = vic_pkg::NUM_SRC
) (
    // Clock, reset, enable
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 clk_en_i,
    // Peripheral events, one-cycle pulses on core clock
    input  wire logic [NUM_SRC-1:0]   src_event_i,
    // Per-source enable bits (bit 0 is watchdog_irq_enable)
    input  wire logic [NUM_SRC-1:0]   src_enable_i,
    // Software flag clear strobes
    input  wire logic [NUM_SRC-1:0]   flag_clear_i,
    // Core instructions
    input  wire vic_pkg::vic_instr_t  instr_i,
    // Fetch acknowledges the vector
    input  wire logic                 vec_ack_i,
    // Vector request and status
    output vic_pkg::vic_vec_t         vec_o,
    output logic [NUM_SRC-1:0]        flags_o,
    output logic                      gie_o,
    output logic                      reset_fetch_o
);

    //==========================================================================
    // Reset release
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    //==========================================================================
    // Reset vector request
    logic reset_fetch_reg;

    // Fetch from 0000 once after reset, above all sources
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            reset_fetch_reg <= 1'b1; // RL2
        else if (clk_en_i && vec_ack_i && vec_o.valid)
            reset_fetch_reg <= 1'b0; // Only once the reset vector was really shown
    end
    assign reset_fetch_o = reset_fetch_reg;

    //==========================================================================
    // Request flags
    logic [NUM_SRC-1:0] flags_reg;
    logic [NUM_SRC-1:0] taken;

    // Set wins over clear; set regardless of mask or global enable
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_flag
            always_ff @(posedge ref_clk_i or negedge rst_n)
            begin
                if (!rst_n)
                    flags_reg[g] <= vic_pkg::FLAG_RST[g];
                else if (clk_en_i)
                begin
                    if (src_event_i[g])
                        flags_reg[g] <= 1'b1; // RL1 RL21
                    else if (flag_clear_i[g])
                        flags_reg[g] <= 1'b0; // RL20
                end
            end
            // Watchdog gated by own enable only; others also need global
            if (g == vic_pkg::SRC_WATCHDOG)
            begin : g_wdt
                assign taken[g] = flags_reg[g] & src_enable_i[g]; // RL3
            end
            else
            begin : g_std
                assign taken[g] = flags_reg[g] & src_enable_i[g] & gie_o; // RL4 RL5 RL6 RL7 RL8 RL9 RL10 RL11 RL12 RL13 RL14 RL15 RL16 RL17
            end
        end
    endgenerate
    assign flags_o = flags_reg; // RL18

    //==========================================================================
    // Global enable
    logic gie_reg;
    logic vec_take;

    // Enable and return set it; disable and vector entry clear it
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            gie_reg <= vic_pkg::GIE_RST;
        else if (clk_en_i)
        begin
            if (instr_i.enable_instr || instr_i.return_instr)
                gie_reg <= 1'b1; // RL18 RL22
            else if (instr_i.disable_instr || vec_take)
                gie_reg <= 1'b0; // RL18
        end
    end
    assign gie_o = gie_reg;

    //==========================================================================
    // Priority selection
    vic_pkg::vic_vec_t sel;

    // Lowest index is highest priority
    always_comb
    begin
        sel = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (taken[i])
            begin
                sel.valid = 1'b1;
                sel.addr  = vic_pkg::VEC_TABLE[i]; // RL19 RL23
                sel.prio  = 4'(i + 1);
            end
        end
        if (reset_fetch_reg)
        begin
            sel.valid = 1'b1;
            sel.addr  = vic_pkg::RESET_VECTOR; // RL2
            sel.prio  = 4'h0;
        end
    end

    //==========================================================================
    // Vector output register
    vic_pkg::vic_vec_t vec_reg;

    assign vec_take = clk_en_i && vec_ack_i && vec_reg.valid && !reset_fetch_reg;

    // Reloads the current selection every enabled cycle; clears once fetch acknowledges it
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            vec_reg <= '0;
        else if (clk_en_i)
        begin
            if (vec_ack_i && vec_reg.valid)
                vec_reg <= '0;
            else
                vec_reg <= sel; // RL19
        end
    end
    assign vec_o = vec_reg;

endmodule

`default_nettype wire

// >>> vic_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vic_top_asserts #(
    parameter int NUM_SRC = 15
) (
    input wire logic                ref_clk_i,
    input wire logic                rst_n_i,
    input wire logic                clk_en_i,
    input wire logic [NUM_SRC-1:0]  src_event_i,
    input wire logic [NUM_SRC-1:0]  src_enable_i,
    input wire vic_pkg::vic_instr_t instr_i,
    input wire logic                vec_ack_i,
    input wire vic_pkg::vic_vec_t   vec_o,
    input wire logic [NUM_SRC-1:0]  flags_o,
    input wire logic                gie_o,
    input wire logic                reset_fetch_o
);
    logic [1:0] age_reg;
    logic       up;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Counts edges until the internal reset copy has let go
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
        if (!rst_n_i) age_reg <= 2'h0;
        else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    assign up = (age_reg == 2'h3);
    chk_event_sets_flag: assert property (
        up && clk_en_i |=> (flags_o & $past(src_event_i)) == $past(src_event_i))
        else $error("event did not set its flag");
    chk_vector_table: assert property (
        vec_o.valid |-> vec_o.addr == (vec_o.prio == 4'h0 ? 12'h000 :
        vic_pkg::VEC_TABLE[vec_o.prio - 4'h1])) else $error("vector address wrong");
    chk_gie_gates_vec: assert property (
        vec_o.valid && vec_o.prio > 4'h1 |-> $past(gie_o)) else $error("vector without gie");
    chk_lowest_wins: assert property (
        vec_o.valid && vec_o.prio != 4'h0 |-> !$past(reset_fetch_o) &&
        ($past(flags_o & src_enable_i) & ((15'h0001 << (vec_o.prio - 4'h1)) - 15'h0001)) == 0)
        else $error("higher priority request skipped");
    chk_ack_drops_vec: assert property (
        vec_o.valid && vec_ack_i && clk_en_i |=> !vec_o.valid) else $error("vector held");
    chk_ack_clears_gie: assert property (
        vec_o.valid && vec_ack_i && clk_en_i && vec_o.prio != 4'h0 && !instr_i.enable_instr
        && !instr_i.return_instr |=> !gie_o) else $error("gie kept on entry");
    chk_return_sets_gie: assert property (
        up && clk_en_i && (instr_i.enable_instr || instr_i.return_instr) |=> gie_o)
        else $error("gie not set");
    chk_disable_gie: assert property (
        clk_en_i && instr_i.disable_instr && !instr_i.enable_instr && !instr_i.return_instr
        |=> !gie_o) else $error("gie not cleared");
    cover property (vec_o.valid && vec_o.prio == 4'h1);
    cover property (vec_o.valid && vec_o.prio == 4'hf);
    cover property (vec_o.valid && vec_ack_i && vec_o.prio == 4'h0);
endmodule
bind vic_top vic_top_asserts #(.NUM_SRC(NUM_SRC)) u_vic_top_asserts (.ref_clk_i, .rst_n_i,
    .clk_en_i, .src_event_i, .src_enable_i, .instr_i, .vec_ack_i, .vec_o, .flags_o, .gie_o,
    .reset_fetch_o);
`default_nettype wire
